/* rtl/pdei_pkg.sv */
// Constants shared by the port D external interrupt detector.
// Assumes a 32-bit AXI4-Lite register window decoded on 12 address bits.
package pdei_pkg;

    localparam int unsigned CHANNELS   = 23;
    localparam int unsigned MODE_W     = 4;
    localparam int unsigned WORD_W     = 32;
    localparam int unsigned MODE_WORDS = 3;
    localparam int unsigned ADDR_W     = 12;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_MODE_LOW  = 12'h260;
    localparam logic [11:0] OFS_MODE_MID  = 12'h264;
    localparam logic [11:0] OFS_MODE_HIGH = 12'h268;
    localparam logic [11:0] OFS_ENABLES   = 12'h270;
    localparam logic [11:0] OFS_PENDING   = 12'h274;
    localparam logic [11:0] OFS_DEBOUNCE  = 12'h278;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned PRESCALE_LSB = 4;
    localparam int unsigned PRESCALE_W   = 3;
    localparam int unsigned DIV_W        = 7;
    localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
    localparam logic [2:0]  RESET_PRESCALE = 3'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Trigger modes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        PDEI_RISE = 4'h0,
        PDEI_FALL = 4'h1,
        PDEI_HIGH = 4'h2,
        PDEI_LOW  = 4'h3,
        PDEI_BOTH = 4'h4
    } pdei_mode_t;

endpackage : pdei_pkg

/* rtl/pdei_det_if.sv */
// Link between the register side and the per-channel trigger detector.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface pdei_det_if #(
    parameter int unsigned CHANNELS = 23
);
    logic                    tick;
    logic [CHANNELS-1:0]     level;
    logic [4*CHANNELS-1:0]   mode;
    logic [CHANNELS-1:0]     hit;

    modport ctrl (output tick, output level, output mode, input hit);
    modport det  (input tick, input level, input mode, output hit);
endinterface : pdei_det_if
`default_nettype wire

/* rtl/pdei_detect.sv */
// Per-channel trigger detector, evaluated on each debounce sample tick.
// Assumes levels are already synchronised to i_clock.
`timescale 1ns/10ps
`default_nettype none
module pdei_detect #(
    parameter int unsigned CHANNELS = 23
) (
    input  wire logic  i_clock,
    input  wire logic  i_rstn,
    input  wire logic  i_ce,
    pdei_det_if.det    det
);
    logic [CHANNELS-1:0] prev_q;
    logic [CHANNELS-1:0] hit_c;

    function automatic logic trig(input logic [3:0] mode, input logic cur, input logic prv);
        case (mode)
            pdei_pkg::PDEI_RISE: trig = cur & ~prv;
            pdei_pkg::PDEI_FALL: trig = ~cur & prv;
            pdei_pkg::PDEI_HIGH: trig = cur;
            pdei_pkg::PDEI_LOW:  trig = ~cur;
            pdei_pkg::PDEI_BOTH: trig = cur ^ prv;
            // Reserved codes never trigger
            default:             trig = 1'b0;
        endcase
    endfunction : trig

    // R7: sampled only on debounce tick
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            prev_q <= '0;
        end else if (i_ce && det.tick) begin
            prev_q <= det.level;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_chan
            // R2: mode decode per channel
            assign hit_c[g] = det.tick & trig(det.mode[4*g +: 4], det.level[g], prev_q[g]);
        end
    endgenerate

    assign det.hit = hit_c;
endmodule : pdei_detect
`default_nettype wire

/* rtl/pdei_top.sv */
// Port D external interrupt detector: mode, enable and pending registers
// behind an AXI4-Lite slave, pin synchronisers and a debounce prescaler.
// Assumes pins are asynchronous and the bus runs on i_clock.
//
// Overview of operation
// R1: 4-bit mode per channel, eight per word
// R2: Modes rise, fall, high, low, both edges
// R3: Third word holds channels 16 to 22
// R4: Enable bit per channel, upper bits unused
// R5: Pending bit per channel, write one clears
// R6: All registers read zero after reset
// R7: Pins sampled at clock over two-power prescale
// R8: Detection sets pending; enabled pending raises interrupt
`timescale 1ns/10ps
`default_nettype none
module pdei_top #(
    parameter int unsigned CHANNELS = pdei_pkg::CHANNELS
) (
    input  wire logic                 i_clock,
    input  wire logic                 i_rstn,
    input  wire logic                 i_ce,
    input  wire logic [CHANNELS-1:0]  i_pins,
    output logic                      o_irq,
    input  wire logic                 i_awvalid,
    output logic                      o_awready,
    input  wire logic [11:0]          i_awaddr,
    input  wire logic                 i_wvalid,
    output logic                      o_wready,
    input  wire logic [31:0]          i_wdata,
    input  wire logic [3:0]           i_wstrb,
    output logic                      o_bvalid,
    input  wire logic                 i_bready,
    output logic [1:0]                o_bresp,
    input  wire logic                 i_arvalid,
    output logic                      o_arready,
    input  wire logic [11:0]          i_araddr,
    output logic                      o_rvalid,
    input  wire logic                 i_rready,
    output logic [31:0]               o_rdata,
    output logic [1:0]                o_rresp
);
    localparam int unsigned MODE_BITS = pdei_pkg::MODE_WORDS * pdei_pkg::WORD_W;

    generate
        if (CHANNELS < 1 || CHANNELS > pdei_pkg::CHANNELS) begin : g_bad
            $error("pdei_top: CHANNELS must be 1 to 23");
        end
    endgenerate

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [MODE_BITS-1:0]       mode_q;
    logic [MODE_BITS-1:0]       mode_d;
    logic [CHANNELS-1:0]        enable_q;
    logic [CHANNELS-1:0]        pending_q;
    logic [CHANNELS-1:0]        pending_d;
    logic [CHANNELS-1:0]        pend_clr;
    logic [2:0]                 prescale_q;
    logic [pdei_pkg::DIV_W-1:0] div_q;
    logic [pdei_pkg::DIV_W-1:0] div_mask;
    logic [CHANNELS-1:0]        sync1_q;
    logic [CHANNELS-1:0]        sync2_q;
    logic                       bvalid_q;
    logic [1:0]                 bresp_q;
    logic                       rvalid_q;
    logic [31:0]                rdata_q;
    logic [1:0]                 rresp_q;
    logic                       wr_en;
    logic                       rd_en;
    logic [31:0]                wmask;
    logic [31:0]                rd_word;
    logic                       rd_ok;
    logic                       wr_ok;
    logic [11:0]                waddr;
    logic [11:0]                raddr;

    pdei_det_if #(.CHANNELS(CHANNELS)) det_bus ();

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    // Second stage is the only reader of the first
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (i_ce) begin
            sync1_q <= i_pins;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // Debounce prescaler
    // ------------------------------------------------------------
    // R7: tick once per two-power cycles
    assign div_mask = pdei_pkg::DIV_W'((8'h01 << prescale_q) - 8'h01);

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            div_q <= '0;
        end else if (i_ce) begin
            div_q <= div_q + 1'b1;
        end
    end

    assign det_bus.tick  = ((div_q & div_mask) == div_mask);
    assign det_bus.level = sync2_q;
    assign det_bus.mode  = mode_q[4*CHANNELS-1:0];

    pdei_detect #(.CHANNELS(CHANNELS)) u_detect (
        .i_clock (i_clock),
        .i_rstn  (i_rstn),
        .i_ce    (i_ce),
        .det     (det_bus)
    );

    // ------------------------------------------------------------
    // AXI4-Lite handshake
    // ------------------------------------------------------------
    // Address and data taken together; simpler than two skid slots
    assign o_awready = i_ce & i_awvalid & i_wvalid & ~bvalid_q;
    assign o_wready  = o_awready;
    assign wr_en     = o_awready;
    assign o_arready = i_ce & ~rvalid_q;
    assign rd_en     = i_arvalid & o_arready;
    assign waddr     = {i_awaddr[11:2], 2'b00};
    assign raddr     = {i_araddr[11:2], 2'b00};

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            wmask[8*b +: 8] = {8{i_wstrb[b]}};
        end
    end

    always_comb begin
        case (waddr)
            pdei_pkg::OFS_MODE_LOW,
            pdei_pkg::OFS_MODE_MID,
            pdei_pkg::OFS_MODE_HIGH,
            pdei_pkg::OFS_ENABLES,
            pdei_pkg::OFS_PENDING,
            pdei_pkg::OFS_DEBOUNCE: wr_ok = 1'b1;
            default:                wr_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Mode registers
    // ------------------------------------------------------------
    always_comb begin
        mode_d = mode_q;
        if (wr_en) begin
            // R1: eight fields per word
            for (int w = 0; w < pdei_pkg::MODE_WORDS; w++) begin
                if (waddr == pdei_pkg::OFS_MODE_LOW + 12'(4 * w)) begin
                    mode_d[32*w +: 32] = (mode_q[32*w +: 32] & ~wmask) | (i_wdata & wmask);
                end
            end
        end
        // R3: channels beyond the port stay zero
        mode_d[MODE_BITS-1:4*CHANNELS] = '0;
    end

    // R6: zero after reset
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            mode_q <= {pdei_pkg::MODE_WORDS{pdei_pkg::RESET_WORD}};
        end else if (i_ce) begin
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------
    // Enable and prescale registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            enable_q   <= '0;
            prescale_q <= pdei_pkg::RESET_PRESCALE;
        end else if (i_ce && wr_en) begin
            // R4: one enable per channel
            if (waddr == pdei_pkg::OFS_ENABLES) begin
                enable_q <= (enable_q & ~wmask[CHANNELS-1:0])
                          | (i_wdata[CHANNELS-1:0] & wmask[CHANNELS-1:0]);
            end
            if (waddr == pdei_pkg::OFS_DEBOUNCE && i_wstrb[0]) begin
                prescale_q <= i_wdata[pdei_pkg::PRESCALE_LSB +: pdei_pkg::PRESCALE_W];
            end
        end
    end

    // ------------------------------------------------------------
    // Pending flags and interrupt
    // ------------------------------------------------------------
    // R5: write one clears, strobed bytes only
    assign pend_clr = (wr_en && waddr == pdei_pkg::OFS_PENDING)
                    ? (i_wdata[CHANNELS-1:0] & wmask[CHANNELS-1:0]) : '0;

    // R8: a new hit wins over a clear
    assign pending_d = (pending_q & ~pend_clr) | det_bus.hit;

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            pending_q <= '0;
        end else if (i_ce) begin
            pending_q <= pending_d;
        end
    end

    // R8: enabled and pending drive the request
    assign o_irq = |(pending_q & enable_q);

    // ------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= pdei_pkg::RESP_OKAY;
        end else if (i_ce) begin
            if (wr_en) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_ok ? pdei_pkg::RESP_OKAY : pdei_pkg::RESP_SLVERR;
            end else if (i_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign o_bvalid = bvalid_q;
    assign o_bresp  = bresp_q;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rd_word = pdei_pkg::RESET_WORD;
        rd_ok   = 1'b1;
        case (raddr)
            pdei_pkg::OFS_MODE_LOW:  rd_word = mode_q[31:0];
            pdei_pkg::OFS_MODE_MID:  rd_word = mode_q[63:32];
            pdei_pkg::OFS_MODE_HIGH: rd_word = mode_q[95:64];
            pdei_pkg::OFS_ENABLES:   rd_word = 32'(enable_q);
            pdei_pkg::OFS_PENDING:   rd_word = 32'(pending_q);
            pdei_pkg::OFS_DEBOUNCE:  rd_word = 32'(prescale_q) << pdei_pkg::PRESCALE_LSB;
            default:                 rd_ok   = 1'b0;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= pdei_pkg::RESET_WORD;
            rresp_q  <= pdei_pkg::RESP_OKAY;
        end else if (i_ce) begin
            if (rd_en) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_word;
                rresp_q  <= rd_ok ? pdei_pkg::RESP_OKAY : pdei_pkg::RESP_SLVERR;
            end else if (i_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    assign o_rvalid = rvalid_q;
    assign o_rdata  = rdata_q;
    assign o_rresp  = rresp_q;
endmodule : pdei_top
`default_nettype wire

/* testbench/pdei_pins_model.sv */
// Model of the external sources on the port's interrupt pins.
// Assumes the bench calls set_pin from its own procedural flow.
`timescale 1ns/10ps
`default_nettype none
module pdei_pins_model #(
    parameter int unsigned CHANNELS = 23
) (
    input  wire logic                i_clock,
    output var logic [CHANNELS-1:0]  o_pins
);
    initial o_pins = '0;
    // Sources are always driven, so no float case
    task automatic set_pin(input int ch, input logic v);
        @(posedge i_clock);
        o_pins[ch] <= v;
    endtask : set_pin
endmodule : pdei_pins_model
`default_nettype wire

/* testbench/pdei_top_asserts.sv */
// Checker on the detector's bus and interrupt ports.
// Assumes i_ce is held high while checking.
`timescale 1ns/10ps
`default_nettype none
module pdei_top_asserts (
    input wire logic        i_clock,
    input wire logic        i_rstn,
    input wire logic        i_ce,
    input wire logic        o_irq,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic [11:0] i_awaddr,
    input wire logic        i_wvalid,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic [1:0]  o_bresp,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [11:0] i_araddr,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0]  o_rresp
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    logic wr_go, rd_go, aw_map, ar_map;
    assign wr_go  = i_awvalid && i_wvalid && o_awready && i_ce;
    assign rd_go  = i_arvalid && o_arready && i_ce;
    assign aw_map = i_awaddr[11:2] inside {10'h098, 10'h099, 10'h09a, 10'h09c, 10'h09d, 10'h09e};
    assign ar_map = i_araddr[11:2] inside {10'h098, 10'h099, 10'h09a, 10'h09c, 10'h09d, 10'h09e};
    AST_RESET_CLEAR: assert property (@(posedge i_clock) disable iff (1'b0)
        !i_rstn |=> !o_irq && !o_bvalid && !o_rvalid) else $error("reset state wrong");
    AST_WR_OKAY: assert property (wr_go && aw_map |=> o_bvalid && o_bresp == 2'h0)
        else $error("mapped write response wrong");
    AST_WR_SLVERR: assert property (wr_go && !aw_map |=> o_bvalid && o_bresp == 2'h2)
        else $error("unmapped write response wrong");
    AST_RD_OKAY: assert property (rd_go && ar_map |=> o_rvalid && o_rresp == 2'h0)
        else $error("mapped read response wrong");
    AST_RD_UNMAPPED: assert property (rd_go && !ar_map |=> o_rresp == 2'h2 && o_rdata == 32'h0)
        else $error("unmapped read answer wrong");
    AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    AST_AW_REFUSE: assert property (o_bvalid |-> !o_awready)
        else $error("write taken while response open");
    AST_IRQ_FALL: assert property ($fell(o_irq) |-> o_bvalid)
        else $error("interrupt dropped without a write");
endmodule : pdei_top_asserts
bind pdei_top pdei_top_asserts u_pdei_top_asserts (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_ce(i_ce), .o_irq(o_irq),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
    .i_wvalid(i_wvalid), .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp));
`default_nettype wire

/* testbench/tb_pdei_top.sv */
// Self-checking bench for the port D interrupt detector.
// Assumes package, design, pin model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) check(32'(g), 32'(e))
module tb_pdei_top;
    logic        clk = 0, rstn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [1:0]  bresp, rresp, br, rr;
    logic        awready, wready, bvalid, arready, rvalid, irq, iq, wq;
    logic [22:0] pins;
    int          n_errors = 0, check_count = 0;
    logic [11:0] regs [6] = '{12'h260, 12'h264, 12'h268, 12'h270, 12'h274, 12'h278};
    logic [31:0] back [6] = '{32'hffff_ffff, 32'hffff_ffff, 32'h0fff_ffff, 32'h007f_ffff,
                              32'h0, 32'h0000_0070};
    logic [3:0]  tbl  [6] = '{4'b0100, 4'b0001, 4'b0111, 4'b1101, 4'b0101, 4'b0000};
    int          chans [3] = '{0, 15, 22};
    always #5 clk = ~clk;
    pdei_pins_model u_pdei_pins_model (.i_clock(clk), .o_pins(pins));
    pdei_top u_pdei_top (.i_clock(clk), .i_rstn(rstn), .i_ce(1'b1), .i_pins(pins), .o_irq(irq),
        .i_awvalid(awv), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wv),
        .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf), .o_bvalid(bvalid),
        .i_bready(bready), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arready),
        .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
        .o_rresp(rresp));
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    task automatic summarize();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    // Sample at the falling edge: settled, and held up to the taking rise
    task automatic wait_hi(ref logic s);
        int   n;
        logic t;
        n = 0;
        do begin
            @(negedge clk);
            t = s;
            rd = rdata;
            rr = rresp;
            br = bresp;
            iq = irq;
            wq = wready;
            @(posedge clk);
            n++;
        end while (t !== 1'b1 && n < 100);
        if (t !== 1'b1) begin
            n_errors++;
            summarize();
        end
    endtask : wait_hi
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
        @(posedge clk);
        awv <= 1'b1;
        wv <= 1'b1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'b1;
        wait_hi(awready);
        `CHK(wq, 1'b1);
        awv <= 1'b0;
        wv <= 1'b0;
        wait_hi(bvalid);
        bready <= 1'b0;
        `CHK(br, e);
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge clk);
        arv <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        wait_hi(arready);
        arv <= 1'b0;
        wait_hi(rvalid);
        rready <= 1'b0;
        `CHK(rd, e);
        `CHK(rr, er);
    endtask : axi_rd
    // Phase 0 clears with pin low then raises it; phase 1 the reverse
    task automatic mode_case(input int ch, input logic [3:0] m, input logic [3:0] x);
        logic [31:0] b;
        b = 32'h1 << ch;
        axi_wr(12'h260 + 12'(4 * (ch / 8)), 32'(m) << (4 * (ch % 8)), 2'h0);
        for (int p = 0; p < 2; p++) begin
            axi_wr(12'h274, 32'h007f_ffff, 2'h0);
            repeat (6) @(posedge clk);
            axi_rd(12'h274, x[3-2*p] ? b : 32'h0, 2'h0);
            `CHK(iq, x[3-2*p]);
            u_pdei_pins_model.set_pin(ch, p == 0);
            repeat (6) @(posedge clk);
            axi_rd(12'h274, x[2-2*p] ? b : 32'h0, 2'h0);
            `CHK(iq, x[2-2*p]);
        end
    endtask : mode_case
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        foreach (regs[i]) axi_rd(regs[i], 32'h0, 2'h0);
        axi_rd(12'h26c, 32'h0, 2'h2);
        axi_wr(12'h26c, 32'hffff_ffff, 2'h2);
        foreach (regs[i]) axi_wr(regs[i], 32'hffff_ffff, 2'h0);
        foreach (regs[i]) axi_rd(regs[i], back[i], 2'h0);
        foreach (regs[i]) axi_wr(regs[i], 32'h0, 2'h0);
        axi_wr(12'h270, 32'h007f_ffff, 2'h0);
        foreach (chans[c]) begin
            for (int m = 0; m < 6; m++) mode_case(chans[c], 4'(m), tbl[m]);
        end
        // Masked channel still latches pending
        axi_wr(12'h270, 32'h0, 2'h0);
        axi_wr(12'h260, 32'h0000_0003, 2'h0);
        repeat (6) @(posedge clk);
        axi_rd(12'h274, 32'h1, 2'h0);
        `CHK(iq, 1'b0);
        axi_wr(12'h270, 32'h1, 2'h0);
        axi_rd(12'h270, 32'h1, 2'h0);
        `CHK(iq, 1'b1);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        axi_rd(12'h270, 32'h0, 2'h0);
        axi_rd(12'h260, 32'h0, 2'h0);
        summarize();
    end
endmodule : tb_pdei_top
`default_nettype wire
